// File: logic/motion_pkg.sv
// Constants, types and state carriers for the motion state and shutdown control block.
package motion_pkg;

  // Register word addresses on the plain register port.
  localparam logic [3:0] ADDR_COMMAND = 4'h0;
  localparam logic [3:0] ADDR_ARGUMENT = 4'h1;
  localparam logic [3:0] ADDR_REF_SECOND = 4'h2;
  localparam logic [3:0] ADDR_SAFE_POS = 4'h3;
  localparam logic [3:0] ADDR_VELOCITY = 4'h4;
  localparam logic [3:0] ADDR_ACCEL = 4'h5;
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h6;
  localparam logic [3:0] ADDR_ACTUAL_POS = 4'h7;
  localparam logic [3:0] ADDR_TARGET_POS = 4'h8;

  // Command codes written to the command register.
  localparam logic [3:0] CMD_SET_TARGET = 4'h1;
  localparam logic [3:0] CMD_GOTO_SAFE = 4'h2;
  localparam logic [3:0] CMD_REFERENCE = 4'h3;
  localparam logic [3:0] CMD_IMMEDIATE_HALT = 4'h4;
  localparam logic [3:0] CMD_DECEL_HALT = 4'h5;
  localparam logic [3:0] CMD_RESET_POSITION = 4'h6;

  // Positions of the monitor inputs inside the synchronised monitor vector.
  localparam int MON_TEMP_TRIP = 0;
  localparam int MON_TEMP_WARN_LO = 1;
  localparam int MON_TEMP_WARN_HI = 2;
  localparam int MON_UV_SHUTDOWN = 3;
  localparam int MON_UV_WARN = 4;
  localparam int MON_SHORT = 5;
  localparam int MON_OPEN = 6;
  localparam int MON_PUMP_FAIL = 7;

  // Safe position code that means the safe position is disabled.
  localparam logic [10:0] SAFE_DISABLED = 11'h400;
  // Values after reset.
  localparam logic [10:0] SAFE_POS_RESET = 11'h400;
  localparam logic [7:0] VMAX_PERIOD_RESET = 8'h10;
  localparam logic [7:0] VMIN_PERIOD_RESET = 8'h80;
  localparam logic [7:0] ACCEL_RESET = 8'h04;
  // Steps taken while decelerating to a halt.
  localparam logic [15:0] DECEL_STEPS = 16'h0010;

  // Main motion states, Gray coded along shutdown, stopped, moving, decel halt.
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'h0,
    ST_STOPPED = 3'h1,
    ST_MOVING = 3'h3,
    ST_DECEL_HALT = 3'h2,
    ST_IMM_HALT = 3'h6,
    ST_REFERENCE = 3'h7
  } motion_state_e;

  // Phases of the reference search.
  typedef enum logic [1:0] {
    REF_FIRST = 2'h0,
    REF_SECOND = 2'h1,
    REF_SAFE = 2'h3,
    REF_DEADLOCK = 2'h2
  } ref_phase_e;

  // Latched status flags.
  typedef struct packed {
    logic thermal_trip;
    logic halt_latched_flag;
    logic electrical_defect_flag;
    logic pump_fail;
    logic lost_steps_flag;
    logic temp_warn_lo;
    logic temp_warn_hi;
    logic low_voltage_warning;
  } flags_s;

  // Drive controls toward the bridge and the step sequencer.
  typedef struct packed {
    logic bridge_hiz;
    logic hold_current_en;
    logic motor_clk_en;
    logic pump_en;
    logic step;
    logic dir;
  } drive_s;

  // Complete state of the control block.
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    motion_state_e state;
    ref_phase_e phase;
    logic signed [15:0] actual_position;
    logic signed [15:0] target_position;
    logic signed [15:0] argument;
    logic signed [15:0] ref_second;
    logic [10:0] safe_position;
    logic [7:0] vmax_period;
    logic [7:0] vmin_period;
    logic [7:0] accel;
    logic [7:0] div_cnt;
    logic [7:0] period;
    logic ramp_en;
    flags_s flags;
    drive_s drive;
    logic [15:0] rdata;
  } ctrl_s;

endpackage

// File: logic/motion_state_shutdown_control.sv
// Motion state, reference search and motor shutdown control of a stepper controller.
`timescale 1ns/10ps

module motion_state_shutdown_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic temp_trip,
  input wire logic temp_warn_lo,
  input wire logic temp_warn_hi,
  input wire logic batt_uv_shutdown,
  input wire logic batt_uv_warn,
  input wire logic bridge_short,
  input wire logic bridge_open,
  input wire logic pump_fail,
  output logic bridge_hiz,
  output logic hold_current_en,
  output logic motor_clk_en,
  output logic pump_en,
  output logic step_pulse,
  output logic step_dir
);

  motion_pkg::ctrl_s q;
  motion_pkg::ctrl_s d;

  logic [7:0] mon_raw;
  logic [7:0] mon;
  logic fault_now;
  logic halt_int;
  logic status_read;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic safe_en;
  logic signed [15:0] safe_target;
  logic at_target;
  logic step_now;
  logic [8:0] ramp_sum;
  logic signed [15:0] decel_span;
  motion_pkg::motion_state_e next_state;

  // Raw monitor pins gathered into one vector for the synchroniser.
  assign mon_raw = {pump_fail, bridge_open, bridge_short, batt_uv_warn,
                    batt_uv_shutdown, temp_warn_hi, temp_warn_lo, temp_trip};
  assign mon = q.sync2;

  // Live fault conditions that force shutdown or an internal halt.
  assign fault_now = mon[motion_pkg::MON_TEMP_TRIP] | mon[motion_pkg::MON_UV_SHUTDOWN] |
                     mon[motion_pkg::MON_SHORT] | mon[motion_pkg::MON_OPEN] |
                     mon[motion_pkg::MON_PUMP_FAIL];
  assign halt_int = fault_now | q.flags.thermal_trip | q.flags.halt_latched_flag;

  // Bus decode of commands and of the status one read.
  assign status_read = rd_stb && (addr == motion_pkg::ADDR_STATUS_ONE);
  assign cmd_valid = wr_stb && (addr == motion_pkg::ADDR_COMMAND);
  assign cmd_code = wdata[3:0];

  // Safe position is scaled to full position resolution by its low zero bits.
  assign safe_en = (q.safe_position != motion_pkg::SAFE_DISABLED);
  assign safe_target = {q.safe_position, 5'h00};

  // Step timing: a step fires when the divider runs out and the target is not reached.
  assign at_target = (q.actual_position == q.target_position);
  assign step_now = !at_target && (q.div_cnt == 8'h00);
  assign ramp_sum = {1'b0, q.vmax_period} + {1'b0, q.accel};
  // Signed copy of the halt distance so that position compares stay signed near zero.
  assign decel_span = $signed(motion_pkg::DECEL_STEPS);

  // Outputs come straight from the state register.
  assign rdata = q.rdata;
  assign bridge_hiz = q.drive.bridge_hiz;
  assign hold_current_en = q.drive.hold_current_en;
  assign motor_clk_en = q.drive.motor_clk_en;
  assign pump_en = q.drive.pump_en;
  assign step_pulse = q.drive.step;
  assign step_dir = q.drive.dir;

  // Next-state logic for the whole block.
  always_comb begin
    d = q;
    next_state = q.state;
    d.sync1 = mon_raw;
    d.sync2 = q.sync1;
    d.drive.step = 1'b0;

    // Flag updates: a live condition sets, a status one read clears, the set wins.
    d.flags.thermal_trip = mon[motion_pkg::MON_TEMP_TRIP] |
                           (q.flags.thermal_trip & ~status_read);
    d.flags.halt_latched_flag = mon[motion_pkg::MON_UV_SHUTDOWN] | mon[motion_pkg::MON_SHORT] |
                                mon[motion_pkg::MON_OPEN] | mon[motion_pkg::MON_PUMP_FAIL] |
                                (q.flags.halt_latched_flag & ~status_read);
    d.flags.electrical_defect_flag = mon[motion_pkg::MON_SHORT] | mon[motion_pkg::MON_OPEN] |
                                     (q.flags.electrical_defect_flag & ~status_read);
    d.flags.pump_fail = mon[motion_pkg::MON_PUMP_FAIL] | (q.flags.pump_fail & ~status_read);
    d.flags.temp_warn_lo = mon[motion_pkg::MON_TEMP_WARN_LO] |
                           (q.flags.temp_warn_lo & ~status_read);
    d.flags.temp_warn_hi = mon[motion_pkg::MON_TEMP_WARN_HI] |
                           (q.flags.temp_warn_hi & ~status_read);
    d.flags.low_voltage_warning = mon[motion_pkg::MON_UV_WARN] |
                                  (q.flags.low_voltage_warning & ~status_read);
    if (status_read) begin
      d.flags.lost_steps_flag = 1'b0;
    end

    // Configuration writes are taken in every state, shutdown included.
    if (wr_stb) begin
      if (addr == motion_pkg::ADDR_ARGUMENT) begin
        d.argument = wdata;
      end else if (addr == motion_pkg::ADDR_REF_SECOND) begin
        d.ref_second = wdata;
      end else if (addr == motion_pkg::ADDR_SAFE_POS) begin
        d.safe_position = wdata[10:0];
      end else if (addr == motion_pkg::ADDR_VELOCITY) begin
        d.vmax_period = wdata[15:8];
        d.vmin_period = wdata[7:0];
      end else if (addr == motion_pkg::ADDR_ACCEL) begin
        d.accel = wdata[7:0];
      end
    end

    // Register reads answer one cycle later with the values before this cycle's update.
    if (rd_stb) begin
      if (addr == motion_pkg::ADDR_STATUS_ONE) begin
        d.rdata = {5'h00, q.state, q.flags};
      end else if (addr == motion_pkg::ADDR_ACTUAL_POS) begin
        d.rdata = q.actual_position;
      end else if (addr == motion_pkg::ADDR_TARGET_POS) begin
        d.rdata = q.target_position;
      end else if (addr == motion_pkg::ADDR_SAFE_POS) begin
        d.rdata = {5'h00, q.safe_position};
      end else if (addr == motion_pkg::ADDR_VELOCITY) begin
        d.rdata = {q.vmax_period, q.vmin_period};
      end else if (addr == motion_pkg::ADDR_ACCEL) begin
        d.rdata = {8'h00, q.accel};
      end else if (addr == motion_pkg::ADDR_ARGUMENT) begin
        d.rdata = q.argument;
      end else if (addr == motion_pkg::ADDR_REF_SECOND) begin
        d.rdata = q.ref_second;
      end else begin
        d.rdata = 16'h0000;
      end
    end

    // Step generator: the divider reloads from the current period on each step.
    if (q.state == motion_pkg::ST_MOVING || q.state == motion_pkg::ST_REFERENCE ||
        q.state == motion_pkg::ST_DECEL_HALT) begin
      if (step_now) begin
        d.div_cnt = q.period;
        d.drive.step = 1'b1;
        d.drive.dir = (q.target_position > q.actual_position);
        if (q.target_position > q.actual_position) begin
          d.actual_position = q.actual_position + 16'sh0001;
        end else begin
          d.actual_position = q.actual_position - 16'sh0001;
        end
        // Ramp the period down toward the max velocity period by the acceleration.
        if (q.ramp_en) begin
          if ({1'b0, q.period} > ramp_sum) begin
            d.period = q.period - q.accel;
          end else begin
            d.period = q.vmax_period;
          end
        end
      end else if (q.div_cnt != 8'h00) begin
        d.div_cnt = q.div_cnt - 8'h01;
      end
    end

    // Main state machine with its per-state command priorities.
    case (q.state)
      motion_pkg::ST_SHUTDOWN: begin
        if (cmd_valid && cmd_code == motion_pkg::CMD_RESET_POSITION) begin
          d.actual_position = 16'sh0000;
          d.target_position = 16'sh0000;
        end
        if (status_read && !fault_now) begin
          next_state = motion_pkg::ST_STOPPED;
        end
      end
      motion_pkg::ST_STOPPED: begin
        if (halt_int) begin
          next_state = motion_pkg::ST_SHUTDOWN;
        end else if (cmd_valid) begin
          if (cmd_code == motion_pkg::CMD_SET_TARGET && !q.flags.lost_steps_flag) begin
            d.target_position = q.argument;
            d.period = q.vmin_period;
            d.ramp_en = 1'b1;
            next_state = motion_pkg::ST_MOVING;
          end else if (cmd_code == motion_pkg::CMD_GOTO_SAFE && !q.flags.lost_steps_flag &&
                       safe_en) begin
            d.target_position = safe_target;
            d.period = q.vmin_period;
            d.ramp_en = 1'b1;
            next_state = motion_pkg::ST_MOVING;
          end else if (cmd_code == motion_pkg::CMD_REFERENCE) begin
            d.period = q.vmin_period;
            d.ramp_en = 1'b1;
            next_state = motion_pkg::ST_REFERENCE;
            if (q.argument == q.actual_position || q.argument == q.ref_second) begin
              d.phase = motion_pkg::REF_DEADLOCK;
            end else begin
              d.phase = motion_pkg::REF_FIRST;
              d.target_position = q.argument;
            end
          end else if (cmd_code == motion_pkg::CMD_RESET_POSITION) begin
            d.actual_position = 16'sh0000;
            d.target_position = 16'sh0000;
          end
        end
      end
      motion_pkg::ST_MOVING: begin
        // Internal or commanded immediate halt first, then decel halt, then set target or go to safe, then target reached.
        if (halt_int || (cmd_valid && cmd_code == motion_pkg::CMD_IMMEDIATE_HALT)) begin
          d.flags.lost_steps_flag = 1'b1;
          next_state = motion_pkg::ST_IMM_HALT;
        end else if (cmd_valid && cmd_code == motion_pkg::CMD_DECEL_HALT) begin
          next_state = motion_pkg::ST_DECEL_HALT;
        end else if (cmd_valid && cmd_code == motion_pkg::CMD_SET_TARGET &&
                     !q.flags.lost_steps_flag) begin
          d.target_position = q.argument;
        end else if (cmd_valid && cmd_code == motion_pkg::CMD_GOTO_SAFE &&
                     !q.flags.lost_steps_flag && safe_en) begin
          d.target_position = safe_target;
        end else if (at_target) begin
          next_state = motion_pkg::ST_STOPPED;
        end
      end
      motion_pkg::ST_REFERENCE: begin
        // Only an immediate halt or a fault cuts the search short; other commands are dropped.
        if (halt_int || (cmd_valid && cmd_code == motion_pkg::CMD_IMMEDIATE_HALT)) begin
          d.flags.lost_steps_flag = 1'b1;
          next_state = motion_pkg::ST_IMM_HALT;
        end else if (at_target) begin
          case (q.phase)
            motion_pkg::REF_FIRST: begin
              d.phase = motion_pkg::REF_SECOND;
              d.target_position = q.ref_second;
              d.period = q.vmin_period;
              d.div_cnt = q.vmin_period;
              d.ramp_en = 1'b0;
            end
            motion_pkg::REF_SECOND: begin
              d.actual_position = 16'sh0000;
              d.ramp_en = 1'b1;
              d.period = q.vmin_period;
              if (safe_en) begin
                d.phase = motion_pkg::REF_SAFE;
                d.target_position = safe_target;
              end else begin
                d.target_position = 16'sh0000;
                next_state = motion_pkg::ST_STOPPED;
              end
            end
            motion_pkg::REF_SAFE: begin
              next_state = motion_pkg::ST_STOPPED;
            end
            default: begin
              d.target_position = q.actual_position;
            end
          endcase
        end
      end
      motion_pkg::ST_DECEL_HALT: begin
        // A decelerating halt shortens the move to a few slow steps past the current point.
        if (halt_int || (cmd_valid && cmd_code == motion_pkg::CMD_IMMEDIATE_HALT)) begin
          d.flags.lost_steps_flag = 1'b1;
          next_state = motion_pkg::ST_IMM_HALT;
        end else if (q.ramp_en) begin
          d.ramp_en = 1'b0;
          d.period = q.vmin_period;
          if (q.target_position > q.actual_position + decel_span) begin
            d.target_position = q.actual_position + decel_span;
          end else if (q.target_position < q.actual_position - decel_span) begin
            d.target_position = q.actual_position - decel_span;
          end
        end else if (at_target) begin
          next_state = motion_pkg::ST_STOPPED;
        end
      end
      motion_pkg::ST_IMM_HALT: begin
        // Motion stops at once; faults or a search deadlock fall into shutdown.
        d.target_position = q.actual_position;
        if (halt_int || q.phase == motion_pkg::REF_DEADLOCK) begin
          next_state = motion_pkg::ST_SHUTDOWN;
        end else begin
          next_state = motion_pkg::ST_STOPPED;
        end
        d.phase = motion_pkg::REF_FIRST;
      end
      default: begin
        next_state = motion_pkg::ST_SHUTDOWN;
      end
    endcase

    // Entering shutdown drops any pending move.
    if (next_state == motion_pkg::ST_SHUTDOWN && q.state != motion_pkg::ST_SHUTDOWN) begin
      d.target_position = d.actual_position;
      d.phase = motion_pkg::REF_FIRST;
    end
    d.state = next_state;

    // Bridge and supply controls follow the next state.
    d.drive.bridge_hiz = (next_state == motion_pkg::ST_SHUTDOWN);
    d.drive.hold_current_en = (next_state != motion_pkg::ST_SHUTDOWN);
    d.drive.motor_clk_en = (next_state != motion_pkg::ST_SHUTDOWN);
    d.drive.pump_en = (next_state != motion_pkg::ST_SHUTDOWN);
  end

  // State register; reset puts the block into shutdown with bridges released.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= motion_pkg::ST_SHUTDOWN;
      q.phase <= motion_pkg::REF_FIRST;
      q.safe_position <= motion_pkg::SAFE_POS_RESET;
      q.vmax_period <= motion_pkg::VMAX_PERIOD_RESET;
      q.vmin_period <= motion_pkg::VMIN_PERIOD_RESET;
      q.accel <= motion_pkg::ACCEL_RESET;
      q.ramp_en <= 1'b1;
      q.drive.bridge_hiz <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule

// File: sim/host_model.sv
// Host bus master that issues single register reads and writes.
`timescale 1ns/10ps
module host_model (
  input wire logic clk_sys,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One bus cycle; a write when w is set; released address and data show inverted values.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule

// File: sim/motion_properties.sv
// Port checker for shutdown entry and exit, stepping and register read timing.
`timescale 1ns/10ps
module motion_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic temp_trip,
  input wire logic batt_uv_shutdown,
  input wire logic bridge_short,
  input wire logic bridge_open,
  input wire logic pump_fail,
  input wire logic bridge_hiz,
  input wire logic hold_current_en,
  input wire logic motor_clk_en,
  input wire logic pump_en,
  input wire logic step_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Faults that always end in shutdown, and every live shutdown cause.
  wire logic bad_any = batt_uv_shutdown || bridge_short || bridge_open || pump_fail;
  wire logic live_any = bad_any || temp_trip;
  sequence fault_held;
    bad_any [*3];
  endsequence
  sequence live_held;
    live_any [*5];
  endsequence
  hiz_gates_off_a: assert property (bridge_hiz |-> !hold_current_en && !motor_clk_en && !pump_en)
    else $error("drive enabled in shutdown");
  run_enables_a: assert property (!bridge_hiz |-> hold_current_en && motor_clk_en && pump_en)
    else $error("drive off outside shutdown");
  fault_shutdown_a: assert property (fault_held |-> ##[0:10] bridge_hiz)
    else $error("no shutdown on fault");
  step_hiz_a: assert property (bridge_hiz |-> !step_pulse)
    else $error("step while bridges off");
  step_single_a: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse too long");
  leave_read_a: assert property ($fell(bridge_hiz) |->
    $past(rd_stb && addr == motion_pkg::ADDR_STATUS_ONE) ||
    $past(rd_stb && addr == motion_pkg::ADDR_STATUS_ONE, 2)) else $error("left shutdown unasked");
  live_blocks_a: assert property (live_held |-> !$fell(bridge_hiz))
    else $error("left shutdown with live fault");
  rdata_hold_a: assert property (!$past(rd_stb) |-> $stable(rdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (rd_stb && addr == 4'hF |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind motion_state_shutdown_control motion_properties i_motion_properties (.*);

// File: sim/tb.sv
// Self-checking bench for the motion state and shutdown control block.
`timescale 1ns/10ps
module tb;
  import motion_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] mon = 8'h00;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, arg;
  logic wr_stb, rd_stb, bridge_hiz, hold_current_en, motor_clk_en, pump_en, step_pulse, step_dir;
  logic taken = 1'b0;
  logic last_dir = 1'b1;
  logic [15:0] exp_q[$], msk_q[$];
  logic [7:0] fb [8] = '{8'h80, 8'h04, 8'h02, 8'h40, 8'h01, 8'h60, 8'h60, 8'h50};
  logic [7:0] sh = 8'hE9;
  int err_total = 0, num_checks = 0, steps = 0, pos = 0, cyc = 0, last_c = 0, gap_min = 0;
  int base, seed = 32'h14a3dd5e;
  always #2 clk_sys = ~clk_sys;
  host_model i_host_model (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb));
  motion_state_shutdown_control i_motion_state_shutdown_control (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .temp_trip(mon[MON_TEMP_TRIP]), .temp_warn_lo(mon[MON_TEMP_WARN_LO]),
    .temp_warn_hi(mon[MON_TEMP_WARN_HI]), .batt_uv_shutdown(mon[MON_UV_SHUTDOWN]),
    .batt_uv_warn(mon[MON_UV_WARN]), .bridge_short(mon[MON_SHORT]),
    .bridge_open(mon[MON_OPEN]), .pump_fail(mon[MON_PUMP_FAIL]), .bridge_hiz(bridge_hiz),
    .hold_current_en(hold_current_en), .motor_clk_en(motor_clk_en), .pump_en(pump_en),
    .step_pulse(step_pulse), .step_dir(step_dir));
  function automatic logic [15:0] drv();
    return {12'h000, bridge_hiz, hold_current_en, motor_clk_en, pump_en};
  endfunction
  function automatic logic [15:0] st(input motion_state_e s, input logic [7:0] f);
    return {5'h00, s, f};
  endfunction
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_host_model.xfer(1'b1, a, d);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] d);
    wr(ADDR_ARGUMENT, d);
    wr(ADDR_COMMAND, {12'h000, c});
  endtask
  // Notes the expected read value and mask, then issues the read.
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_host_model.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_steps(input int n);
    for (int i = 0; i < 20000 && steps < n; i++) @(negedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compares read data in the cycle after each taken read strobe.
  always @(posedge clk_sys) taken <= rd_stb;
  always @(negedge clk_sys) begin
    if (taken === 1'b1 && exp_q.size() > 0) begin
      check("read data", exp_q[0], rdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // Follows position from step pulses and times down steps at slow speed.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (step_pulse === 1'b1) begin
      steps <= steps + 1;
      pos <= step_dir ? pos + 1 : pos - 1;
      if (!step_dir && !last_dir && cyc - last_c < gap_min) gap_min <= cyc - last_c;
      last_c <= cyc;
      last_dir <= step_dir;
    end
  end
  // Cuts a hung run short.
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    check("drive after reset", 16'h0008, drv());
    rd(ADDR_STATUS_ONE, st(ST_SHUTDOWN, 8'h00), 16'h0700);
    idle(3);
    check("drive after wake", 16'h0007, drv());
    rd(ADDR_SAFE_POS, SAFE_POS_RESET, 16'h07FF);
    rd(ADDR_VELOCITY, {VMAX_PERIOD_RESET, VMIN_PERIOD_RESET}, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      mon <= 8'h01 << i;
      idle(20);
      check("drive on monitor", sh[i] ? 16'h0008 : 16'h0007, drv());
      rd(ADDR_STATUS_ONE, st(sh[i] ? ST_SHUTDOWN : ST_STOPPED, fb[i]), 16'h0700 | fb[i]);
      check("drive fault live", sh[i] ? 16'h0008 : 16'h0007, drv());
      @(posedge clk_sys);
      mon <= 8'h00;
      idle(6);
      rd(ADDR_STATUS_ONE, st(sh[i] ? ST_SHUTDOWN : ST_STOPPED, fb[i]), 16'h0700 | fb[i]);
      rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h00), 16'h0700 | fb[i]);
      check("drive after clear", 16'h0007, drv());
    end
    $display("test monitors done");
    arg = 16'h0001 + 16'($random(seed) & 7);
    base = steps;
    cmd(CMD_SET_TARGET, arg);
    rd(ADDR_STATUS_ONE, st(ST_MOVING, 8'h00), 16'h0700);
    wait_steps(base + int'(arg));
    idle(300);
    rd(ADDR_ACTUAL_POS, arg, 16'hFFFF);
    rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h00), 16'h0700);
    cmd(CMD_SET_TARGET, 16'h0100);
    wr(ADDR_COMMAND, {12'h000, CMD_DECEL_HALT});
    rd(ADDR_STATUS_ONE, st(ST_DECEL_HALT, 8'h00), 16'h0700);
    wr(ADDR_COMMAND, {12'h000, CMD_IMMEDIATE_HALT});
    wr(ADDR_SAFE_POS, 16'h0001);
    idle(300);
    base = steps;
    cmd(CMD_SET_TARGET, 16'h0200);
    wr(ADDR_COMMAND, {12'h000, CMD_GOTO_SAFE});
    idle(400);
    check("steps while lost", 16'(base), 16'(steps));
    rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h08), 16'h0708);
    rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h00), 16'h0708);
    $display("test halts done");
    wr(ADDR_COMMAND, {12'h000, CMD_RESET_POSITION});
    pos = 0;
    cmd(CMD_SET_TARGET, 16'h0040);
    idle(700);
    @(posedge clk_sys);
    mon <= 8'h80;
    idle(30);
    check("drive on pump fault", 16'h0008, drv());
    rd(ADDR_ACTUAL_POS, 16'(pos), 16'hFFFF);
    rd(ADDR_TARGET_POS, 16'(pos), 16'hFFFF);
    @(posedge clk_sys);
    mon <= 8'h00;
    idle(6);
    rd(ADDR_STATUS_ONE, st(ST_SHUTDOWN, 8'h00), 16'h0700);
    rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h00), 16'h0700);
    $display("test moving fault done");
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_COMMAND, {12'h000, CMD_RESET_POSITION});
      wr(ADDR_SAFE_POS, k ? 16'h0001 : 16'h0400);
      wr(ADDR_REF_SECOND, 16'h000A);
      gap_min = 99999;
      base = steps;
      cmd(CMD_REFERENCE, 16'h0014);
      cmd(CMD_SET_TARGET, 16'h0300);
      wait_steps(base + (k ? 62 : 30));
      idle(400);
      check("reference steps", k ? 16'd62 : 16'd30, 16'(steps - base));
      check("slow step gap", 16'h0001, 16'(gap_min >= int'(VMIN_PERIOD_RESET) + 1));
      rd(ADDR_ACTUAL_POS, k ? 16'h0020 : 16'h0000, 16'hFFFF);
      rd(ADDR_STATUS_ONE, st(ST_STOPPED, 8'h00), 16'h0700);
    end
    cmd(CMD_REFERENCE, 16'h0020);
    idle(200);
    rd(ADDR_STATUS_ONE, st(ST_REFERENCE, 8'h00), 16'h0700);
    wr(ADDR_COMMAND, {12'h000, CMD_IMMEDIATE_HALT});
    idle(20);
    check("drive in deadlock halt", 16'h0008, drv());
    rd(ADDR_STATUS_ONE, st(ST_SHUTDOWN, 8'h00), 16'h0700);
    idle(3);
    check("drive after deadlock", 16'h0007, drv());
    $display("test reference done");
    idle(4);
    wrap_up();
  end
endmodule
